// file: core/tcm_ch12_mode.sv
// Mode configuration for timer channels 1 and 2.
//
// Our own choices: the address-and-strobe port and the register offsets.
module tcm_ch12_mode #(
  parameter int CNT_W   = tcm_pkg::CNT_W,
  parameter int DTS_DIV = tcm_pkg::DTS_DIV_DEF
) (
  input  wire logic                        sys_clk_i,
  input  wire logic                        rst_i,
  input  wire logic [tcm_pkg::ADDR_W-1:0]  reg_addr_i,
  input  wire logic [tcm_pkg::DATA_W-1:0]  reg_wdata_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  output logic      [tcm_pkg::DATA_W-1:0]  reg_rdata_o,
  input  wire logic [CNT_W-1:0]            counter_value_i,
  input  wire logic                        count_down_i,
  input  wire logic                        overflow_i,
  input  wire logic                        trigger_event_i,
  input  wire logic                        slave_trigger_input_i,
  input  wire logic                        ch1_pin_i,
  input  wire logic                        ch2_pin_i,
  output logic                             ch1_raw_output_o,
  output logic                             ch1_capture_o,
  output logic                             ch2_capture_o
);
  import tcm_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [15:0]        mode_q;
  logic [15:0]        mode_d;
  logic [2:0]         ctrl_q;
  logic [2:0]         ctrl_d;
  logic [CNT_W-1:0]   cmp_act_q;
  logic [CNT_W-1:0]   cmp_act_d;
  logic [CNT_W-1:0]   cmp_buf_q;
  logic [CNT_W-1:0]   cmp_buf_d;
  logic [1:0]         sync1_q;
  logic [1:0]         sync2_q;
  logic [7:0]         dts_cnt_q;
  logic [7:0]         dts_cnt_d;
  logic               dts_tick;
  logic [4:0]         pre_cnt_q;
  logic [4:0]         pre_cnt_d;
  logic [1:0]         prev_in_q;
  logic [1:0]         prev_in_d;
  logic [2:0]         psc_cnt_q [2];
  logic [2:0]         psc_cnt_d [2];
  logic [1:0]         cap_q;
  logic [1:0]         cap_d;
  logic               raw_q;
  logic               raw_d;
  logic [DATA_W-1:0]  rdata_q;
  logic [DATA_W-1:0]  rdata_d;

  // Per-channel decoded views of the mode and control registers, plus filter, routing and sampling signals.
  tcm_dir_t           dir    [2];
  logic [3:0]         fcode  [2];
  logic [1:0]         psc    [2];
  logic [1:0]         chan_on;
  logic [1:0]         filt;
  logic [1:0]         sel_in;
  logic [1:0]         samp_en;
  logic [3:0]         need   [2];
  logic [2:0]         shift  [2];
  logic [1:0]         kern;

  // ----------------------------------------------------------------------
  // Filter code decode
  // ----------------------------------------------------------------------
  // Returns {kernel-rate flag, base-clock divide shift, sample count N}.
  function automatic logic [7:0] filt_decode(input logic [3:0] code);
    logic [7:0] r;
    r = 8'h00;
    case (code)
      4'h0:    r = {1'b0, 3'd0, 4'd1};  // [RL9]
      4'h1:    r = {1'b1, 3'd0, 4'd2};  // [RL9]
      4'h2:    r = {1'b1, 3'd0, 4'd4};  // [RL9]
      4'h3:    r = {1'b1, 3'd0, 4'd8};  // [RL9]
      4'h4:    r = {1'b0, 3'd1, 4'd6};  // [RL10]
      4'h5:    r = {1'b0, 3'd1, 4'd8};  // [RL10]
      4'h6:    r = {1'b0, 3'd2, 4'd6};  // [RL10]
      4'h7:    r = {1'b0, 3'd2, 4'd8};  // [RL10]
      4'h8:    r = {1'b0, 3'd3, 4'd6};  // [RL11]
      4'h9:    r = {1'b0, 3'd3, 4'd8};  // [RL11]
      4'hA:    r = {1'b0, 3'd4, 4'd5};  // [RL11]
      4'hB:    r = {1'b0, 3'd4, 4'd6};  // [RL11]
      4'hC:    r = {1'b0, 3'd4, 4'd8};  // [RL11]
      4'hD:    r = {1'b0, 3'd5, 4'd5};  // [RL11]
      4'hE:    r = {1'b0, 3'd5, 4'd6};  // [RL11]
      4'hF:    r = {1'b0, 3'd5, 4'd8};  // [RL11]
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Field views
  // ----------------------------------------------------------------------
  // Filter and prescaler bits only count while a channel is an input;
  // in output mode channel 1 uses the same bits for buffering and behaviour controls.
  always_comb begin
    dir[0]     = tcm_dir_t'(mode_q[CH1_DIR_LSB +: 2]);
    dir[1]     = tcm_dir_t'(mode_q[CH2_DIR_LSB +: 2]);
    fcode[0]   = (dir[0] == TCM_DIR_OUT) ? FILT_NONE : mode_q[CH1_FILT_LSB +: 4]; // [RL16]
    fcode[1]   = (dir[1] == TCM_DIR_OUT) ? FILT_NONE : mode_q[CH2_FILT_LSB +: 4]; // [RL14]
    psc[0]     = (dir[0] == TCM_DIR_OUT) ? 2'b00 : mode_q[CH1_PSC_LSB +: 2];      // [RL16]
    psc[1]     = (dir[1] == TCM_DIR_OUT) ? 2'b00 : mode_q[CH2_PSC_LSB +: 2];      // [RL14]
    chan_on[0] = ctrl_q[CTRL_CH1_ON_BIT];
    chan_on[1] = ctrl_q[CTRL_CH2_ON_BIT];
    for (int c = 0; c < 2; c++) begin
      {kern[c], shift[c], need[c]} = filt_decode(fcode[c]);
    end
  end

  // ----------------------------------------------------------------------
  // Sampling clock enables
  // ----------------------------------------------------------------------
  // The sampling base is a divided tick of the kernel clock; the five-bit
  // prescaler gives the /2 to /32 rates without any extra clock domain.
  always_comb begin
    dts_tick  = (dts_cnt_q == 8'(DTS_DIV - 1));
    dts_cnt_d = dts_tick ? 8'h00 : dts_cnt_q + 8'h01;
    pre_cnt_d = dts_tick ? pre_cnt_q + 5'h01 : pre_cnt_q;
    for (int c = 0; c < 2; c++) begin
      if (kern[c]) begin
        samp_en[c] = 1'b1;
      end else begin
        samp_en[c] = dts_tick && ((pre_cnt_q & 5'((1 << shift[c]) - 1)) == 5'h00);
      end
    end
  end

  // Sampling state registers; the pins pass two flip-flops first.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      dts_cnt_q <= 8'h00;
      pre_cnt_q <= 5'h00;
      sync1_q   <= 2'b00;
      sync2_q   <= 2'b00;
    end else begin
      dts_cnt_q <= dts_cnt_d;
      pre_cnt_q <= pre_cnt_d;
      sync1_q   <= {ch2_pin_i, ch1_pin_i};
      sync2_q   <= sync1_q;
    end
  end

  // ----------------------------------------------------------------------
  // Input filters, one per pin
  // ----------------------------------------------------------------------
  generate
    for (genvar g = 0; g < 2; g++) begin : g_filt
      tcm_input_filter u_filt (
        .sys_clk_i   (sys_clk_i),
        .rst_i       (rst_i),
        .sample_en_i (samp_en[g]),
        .bypass_i    (fcode[g] == FILT_NONE),
        .need_i      (need[g]),
        .din_i       (sync2_q[g]),
        .dout_o      (filt[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Input routing, edge detect and capture prescaler
  // ----------------------------------------------------------------------
  // Only rising edges are active here; polarity handling lives elsewhere.
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      case (dir[c])
        TCM_DIR_OUT:   sel_in[c] = 1'b0;                                    // [RL4] [RL7]
        TCM_DIR_OWN:   sel_in[c] = filt[c];                                 // [RL4] [RL7]
        TCM_DIR_OTHER: sel_in[c] = filt[1-c];                               // [RL4] [RL7]
        TCM_DIR_TRIG:  sel_in[c] = slave_trigger_input_i
                                   & ctrl_q[CTRL_TRG_INT_BIT];              // [RL5] [RL7]
        default:       sel_in[c] = 1'b0;
      endcase
      prev_in_d[c]  = sel_in[c];
      cap_d[c]      = 1'b0;
      psc_cnt_d[c]  = psc_cnt_q[c];
      if (!chan_on[c]) begin
        psc_cnt_d[c] = 3'h0;                                                // [RL13]
      end else if (sel_in[c] && !prev_in_q[c]) begin
        // Divisor 1, 2, 4 or 8 gives a terminal count of 0, 1, 3 or 7.
        if (psc_cnt_q[c] == {psc[c] == 2'b11, psc[c][1], psc[c] != 2'b00}) begin
          psc_cnt_d[c] = 3'h0;
          cap_d[c]     = 1'b1;                                              // [RL12]
        end else begin
          psc_cnt_d[c] = psc_cnt_q[c] + 3'h1;                               // [RL12]
        end
      end
    end
  end

  // Capture path registers.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      prev_in_q    <= 2'b00;
      psc_cnt_q[0] <= 3'h0;
      psc_cnt_q[1] <= 3'h0;
      cap_q        <= 2'b00;
    end else begin
      prev_in_q    <= prev_in_d;
      psc_cnt_q[0] <= psc_cnt_d[0];
      psc_cnt_q[1] <= psc_cnt_d[1];
      cap_q        <= cap_d;
    end
  end

  // ----------------------------------------------------------------------
  // Register writes and compare buffering
  // ----------------------------------------------------------------------
  // Direction fields are taken as written; software keeps the channel
  // disabled while it changes them, so no glitch guard is built in. [RL6]
  always_comb begin
    mode_d    = mode_q;
    ctrl_d    = ctrl_q;
    cmp_act_d = cmp_act_q;
    cmp_buf_d = cmp_buf_q;
    if (overflow_i && mode_q[CH1_BUF_BIT] && dir[0] == TCM_DIR_OUT) begin  // [RL16]
      cmp_act_d = cmp_buf_q;                                                // [RL2]
    end
    if (reg_wr_i) begin
      case (reg_addr_i)
        OFS_MODE: mode_d = reg_wdata_i[15:0];
        OFS_CTRL: ctrl_d = reg_wdata_i[2:0];
        OFS_CMP: begin
          if (mode_q[CH1_BUF_BIT] && dir[0] == TCM_DIR_OUT) begin          // [RL16]
            cmp_buf_d = reg_wdata_i[CNT_W-1:0];                             // [RL2]
          end else begin
            cmp_act_d = reg_wdata_i[CNT_W-1:0];                             // [RL1]
            cmp_buf_d = reg_wdata_i[CNT_W-1:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Configuration registers; everything clears on reset.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mode_q    <= MODE_RST;                                                // [RL17]
      ctrl_q    <= CTRL_RST;
      cmp_act_q <= '0;
      cmp_buf_q <= '0;
    end else begin
      mode_q    <= mode_d;
      ctrl_q    <= ctrl_d;
      cmp_act_q <= cmp_act_d;
      cmp_buf_q <= cmp_buf_d;
    end
  end

  // ----------------------------------------------------------------------
  // PWM raw output
  // ----------------------------------------------------------------------
  // A fast-output trigger forces the active level for that cycle; the
  // comparison takes over again from the next cycle.
  always_comb begin
    logic [2:0] beh;
    logic       lvl_a;
    beh   = mode_q[CH1_BEH_LSB +: 3];
    lvl_a = count_down_i ? (cmp_act_q >= counter_value_i)
                         : (cmp_act_q > counter_value_i);                   // [RL15]
    raw_d = 1'b0;
    if (dir[0] == TCM_DIR_OUT && (beh == BEH_PWM_A || beh == BEH_PWM_B)) begin
      if (mode_q[CH1_FAST_BIT] && trigger_event_i) begin
        raw_d = (beh == BEH_PWM_A);                                         // [RL3]
      end else begin
        raw_d = (beh == BEH_PWM_A) ? lvl_a : !lvl_a;                        // [RL3] [RL15]
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------
  always_comb begin
    rdata_d = '0;
    if (reg_rd_i) begin
      case (reg_addr_i)
        OFS_MODE:   rdata_d[15:0]      = mode_q;
        OFS_CMP:    rdata_d[CNT_W-1:0] = cmp_act_q;
        OFS_CMPBUF: rdata_d[CNT_W-1:0] = cmp_buf_q;
        OFS_CTRL:   rdata_d[2:0]       = ctrl_q;
        OFS_STATUS: rdata_d[8:0]       = {filt, psc_cnt_q[1], psc_cnt_q[0], raw_q};
        default:    rdata_d            = '0;  // Unmapped addresses read zero.
      endcase
    end
  end

  // Output registers.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      raw_q   <= 1'b0;
      rdata_q <= '0;
    end else begin
      raw_q   <= raw_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o      = rdata_q;
  assign ch1_raw_output_o = raw_q;
  assign ch1_capture_o    = cap_q[0];
  assign ch2_capture_o    = cap_q[1];

endmodule

// file: core/tcm_pkg.sv
// Functional notes
// RL1: Buffering off: a compare write updates the active compare value at once.
// RL2: Buffering on: writes go to a buffer, copied to active compare on overflow.
// RL3: PWM with fast output: trigger drives the output now, else compare decides.
// RL4: Channel 1 direction: 00 output, 01 own filtered pin, 10 channel 2 pin.
// RL5: Direction 11 takes the slave trigger, valid only with an internal trigger source.
// RL6: Software changes direction fields only while the channel is disabled.
// RL7: Channel 2 direction: 00 output, 01 own pin, 10 channel 1 pin, 11 trigger.
// RL8: Filter passes an edge after N consecutive samples of the new level.
// RL9: Filter 0000 unfiltered at base rate; 0001-0011 kernel rate, N 2, 4, 8.
// RL10: Filter 0100/0101 base/2 N 6,8; 0110/0111 base/4 N 6,8.
// RL11: Filter 1000/1001 base/8; 1010-1100 base/16; 1101-1111 base/32.
// RL12: Capture prescaler: every edge, or every 2nd, 4th, 8th active edge.
// RL13: Capture prescaler count clears whenever the channel enable is clear.
// RL14: Channel 2 filter at bits 15:12, prescaler at bits 11:10.
// RL15: PWM A up-count: high while compare above counter; PWM B inverse.
// RL16: Upper fields of each byte mean output or input controls per direction.
// RL17: All configuration fields reset to zero.
package tcm_pkg;

  // ----------------------------------------------------------------------
  // Bus and widths
  // ----------------------------------------------------------------------
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 32;
  localparam int CNT_W       = 16;
  localparam int DTS_DIV_DEF = 1;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_MODE   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CMP    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CMPBUF = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;

  // ----------------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------------
  localparam int CH1_DIR_LSB  = 0;
  localparam int CH1_FAST_BIT = 2;
  localparam int CH1_BUF_BIT  = 3;
  localparam int CH1_BEH_LSB  = 4;
  localparam int CH1_PSC_LSB  = 2;
  localparam int CH1_FILT_LSB = 4;
  localparam int CH2_DIR_LSB  = 8;
  localparam int CH2_PSC_LSB  = 10;
  localparam int CH2_FILT_LSB = 12;

  // ----------------------------------------------------------------------
  // Control register fields and reset values
  // ----------------------------------------------------------------------
  localparam int CTRL_CH1_ON_BIT  = 0;
  localparam int CTRL_CH2_ON_BIT  = 1;
  localparam int CTRL_TRG_INT_BIT = 2;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [2:0]  CTRL_RST = 3'h0;

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    TCM_DIR_OUT   = 2'b00,
    TCM_DIR_OWN   = 2'b01,
    TCM_DIR_OTHER = 2'b10,
    TCM_DIR_TRIG  = 2'b11
  } tcm_dir_t;

  localparam logic [2:0] BEH_PWM_A = 3'b110;
  localparam logic [2:0] BEH_PWM_B = 3'b111;
  localparam logic [3:0] FILT_NONE = 4'h0;

endpackage

// file: core/tcm_input_filter.sv
// Confirms a level change on one input after a run of equal samples.
module tcm_input_filter (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       sample_en_i,
  input  wire logic       bypass_i,
  input  wire logic [3:0] need_i,
  input  wire logic       din_i,
  output logic            dout_o
);
  import tcm_pkg::*;

  logic [3:0] run_q;
  logic [3:0] run_d;
  logic       lvl_q;
  logic       lvl_d;

  // ----------------------------------------------------------------------
  // Sample counting
  // ----------------------------------------------------------------------
  // A sample equal to the output level restarts the run, so glitches
  // shorter than the window never reach the capture logic.
  always_comb begin
    run_d = run_q;
    lvl_d = lvl_q;
    if (sample_en_i) begin
      if (bypass_i) begin
        lvl_d = din_i;
        run_d = 4'h0;
      end else if (din_i == lvl_q) begin
        run_d = 4'h0;
      end else if (run_q + 4'h1 >= need_i) begin
        lvl_d = din_i; // [RL8]
        run_d = 4'h0;
      end else begin
        run_d = run_q + 4'h1;
      end
    end
  end

  // Registering stage.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      run_q <= 4'h0;
      lvl_q <= 1'b0;
    end else begin
      run_q <= run_d;
      lvl_q <= lvl_d;
    end
  end

  assign dout_o = lvl_q;

endmodule

// file: sim/tcm_ch12_mode_chk.sv
module tcm_ch12_mode_chk #(
  parameter int CNT_W   = 16,
  parameter int DTS_DIV = 1
) (
  input wire logic                       sys_clk_i,
  input wire logic                       rst_i,
  input wire logic [tcm_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [tcm_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic                       reg_wr_i,
  input wire logic                       reg_rd_i,
  input wire logic [tcm_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic [CNT_W-1:0]           counter_value_i,
  input wire logic                       count_down_i,
  input wire logic                       overflow_i,
  input wire logic                       trigger_event_i,
  input wire logic                       slave_trigger_input_i,
  input wire logic                       ch1_pin_i,
  input wire logic                       ch2_pin_i,
  input wire logic                       ch1_raw_output_o,
  input wire logic                       ch1_capture_o,
  input wire logic                       ch2_capture_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import tcm_pkg::*;
  logic [15:0]      mode_q;
  logic [2:0]       ctrl_q;
  logic [CNT_W-1:0] act_q;
  logic [CNT_W-1:0] buf_q;
  logic             buf_on;
  logic             cmp_wr;
  assign buf_on = mode_q[CH1_BUF_BIT] && (mode_q[1:0] == 2'b00);
  assign cmp_wr = reg_wr_i && (reg_addr_i == OFS_CMP);
  // Mirror of the settings, rebuilt from bus writes so the outputs can be judged.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mode_q <= 16'h0000;
      ctrl_q <= 3'h0;
      act_q  <= '0;
      buf_q  <= '0;
    end else begin
      if (reg_wr_i && reg_addr_i == OFS_MODE) mode_q <= reg_wdata_i[15:0];
      if (reg_wr_i && reg_addr_i == OFS_CTRL) ctrl_q <= reg_wdata_i[2:0];
      if (cmp_wr) buf_q <= reg_wdata_i[CNT_W-1:0];
      if (cmp_wr && !buf_on) act_q <= reg_wdata_i[CNT_W-1:0];
      else if (overflow_i && buf_on) act_q <= buf_q;
    end
  end
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  AST_RST_OUT_LOW: assert property (
    $fell(rst_i) |-> !ch1_raw_output_o && !ch1_capture_o && !ch2_capture_o)
    else $error("outputs not low after reset");
  AST_MODE_READ: assert property (
    $past(reg_rd_i) && $past(reg_addr_i) == OFS_MODE |-> reg_rdata_o == {16'h0000, $past(mode_q)})
    else $error("mode readback differs");
  AST_PWM_A_UP: assert property (
    !$past(rst_i) && $past({mode_q[6:4], mode_q[2:0]}) == 6'b110000 && !$past(count_down_i)
    |-> ch1_raw_output_o == ($past(act_q) > $past(counter_value_i)))
    else $error("mode A output wrong");
  AST_PWM_B_DOWN: assert property (
    !$past(rst_i) && $past({mode_q[6:4], mode_q[2:0]}) == 6'b111000 && $past(count_down_i)
    |-> ch1_raw_output_o == ($past(act_q) < $past(counter_value_i)))
    else $error("mode B output wrong");
  AST_FAST_OUT: assert property (
    !$past(rst_i) && $past(trigger_event_i) && $past({mode_q[6:5], mode_q[2:0]}) == 5'b11100
    |-> ch1_raw_output_o == !$past(mode_q[4]))
    else $error("fast output ignored trigger");
  AST_CAP1_NEEDS_ON: assert property (
    ch1_capture_o |-> $past(ctrl_q[0]))
    else $error("capture on disabled channel 1");
  AST_CAP1_DIR_IN: assert property (
    ch1_capture_o |-> $past(mode_q[1:0]) != 2'b00)
    else $error("capture on output channel 1");
  AST_CAP2_DIR_IN: assert property (
    ch2_capture_o |-> $past(mode_q[9:8]) != 2'b00 && $past(ctrl_q[1]))
    else $error("capture on idle channel 2");
  AST_CAP1_LATENCY: assert property (
    ctrl_q[0] && mode_q[7:0] == 8'h01 && $rose(ch1_pin_i) |-> ##4 ch1_capture_o)
    else $error("unfiltered capture late");
  AST_CAP1_ONE_CYCLE: assert property (
    ch1_capture_o |=> !ch1_capture_o)
    else $error("capture pulse too long");
  cover property (ch1_capture_o);
  cover property (ch2_capture_o);
  cover property ($past(trigger_event_i) && ch1_raw_output_o);
endmodule

bind tcm_ch12_mode tcm_ch12_mode_chk #(.CNT_W(CNT_W), .DTS_DIV(DTS_DIV)) u_tcm_ch12_mode_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .counter_value_i(counter_value_i), .count_down_i(count_down_i), .overflow_i(overflow_i),
  .trigger_event_i(trigger_event_i), .slave_trigger_input_i(slave_trigger_input_i),
  .ch1_pin_i(ch1_pin_i), .ch2_pin_i(ch2_pin_i), .ch1_raw_output_o(ch1_raw_output_o),
  .ch1_capture_o(ch1_capture_o), .ch2_capture_o(ch2_capture_o));

// file: sim/tcm_pin_model.sv
// Outside world: two input pins and the slave trigger, pulsed on request.
module tcm_pin_model (
  input  wire logic       sys_clk_i,
  input  wire logic       go_i,
  input  wire logic [1:0] sel_i,
  input  wire logic [8:0] len_i,
  output logic            ch1_pin_o,
  output logic            ch2_pin_o,
  output logic            trig_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] left_q = 9'h000;
  logic [1:0] sel_q  = 2'h0;
  // A line stays high for the requested count; a count of one is a glitch.
  always @(posedge sys_clk_i) begin
    if (go_i) begin
      left_q <= len_i;
      sel_q  <= sel_i;
    end else if (left_q != 9'h000) begin
      left_q <= left_q - 9'h001;
    end
  end
  assign ch1_pin_o = (left_q != 9'h000) && (sel_q == 2'h0);
  assign ch2_pin_o = (left_q != 9'h000) && (sel_q == 2'h1);
  assign trig_o    = (left_q != 9'h000) && (sel_q == 2'h2);
endmodule

// file: sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tcm_pkg::*;
  logic        sys_clk_i, rst_i, reg_wr_i, reg_rd_i, overflow_i, trigger_event_i;
  logic        count_down_i, p1, p2, st, raw, cap1, cap2, go, rd_prev;
  logic [7:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, rdata, v, exp_q[$];
  logic [15:0] counter_value_i;
  logic [1:0]  sel;
  logic [8:0]  len;
  int          fails, comparisons, cnt1, cnt2, b1, b2;
  tcm_ch12_mode #(.CNT_W(16), .DTS_DIV(1)) u_tcm_ch12_mode (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata),
    .counter_value_i(counter_value_i), .count_down_i(count_down_i), .overflow_i(overflow_i),
    .trigger_event_i(trigger_event_i), .slave_trigger_input_i(st), .ch1_pin_i(p1),
    .ch2_pin_i(p2), .ch1_raw_output_o(raw), .ch1_capture_o(cap1), .ch2_capture_o(cap2));
  tcm_pin_model u_tcm_pin_model (.sys_clk_i(sys_clk_i), .go_i(go), .sel_i(sel), .len_i(len),
    .ch1_pin_o(p1), .ch2_pin_o(p2), .trig_o(st));
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_rd();
    cmp_val(rdata, exp_q.pop_front());
  endtask
  task automatic complete_run();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
  endtask
  task automatic setup(input logic [15:0] m, input logic [2:0] c);
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_MODE, {16'h0000, m});
    wr(OFS_CTRL, {29'h0, c});
    b1 = cnt1;
    b2 = cnt2;
  endtask
  task automatic pulse(input logic [1:0] s, input logic [8:0] l, input int g);
    @(posedge sys_clk_i);
    go  <= 1'b1;
    sel <= s;
    len <= l;
    @(posedge sys_clk_i);
    go <= 1'b0;
    repeat (int'(l) + g) @(posedge sys_clk_i);
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  // Read data is due one cycle after the strobe; the oldest note is matched.
  always @(posedge sys_clk_i) begin
    if (rd_prev === 1'b1) cmp_rd();
    rd_prev <= reg_rd_i;
  end
  // Tally capture pulses and keep the counter input moving at random.
  always @(posedge sys_clk_i) begin
    if (cap1 === 1'b1) cnt1++;
    if (cap2 === 1'b1) cnt2++;
    counter_value_i <= 16'($urandom);
    count_down_i    <= 1'($urandom);
  end
  // A hang is cut short and counted as a mismatch.
  initial begin
    repeat (100000) @(posedge sys_clk_i);
    fails++;
    complete_run();
  end
  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    void'($urandom(42));
    {rst_i, reg_wr_i, reg_rd_i, overflow_i, trigger_event_i, go, rd_prev} = 7'h7F;
    {reg_wr_i, reg_rd_i, overflow_i, trigger_event_i, go, rd_prev} = 6'h00;
    {reg_addr_i, reg_wdata_i, counter_value_i, count_down_i, sel, len} = '0;
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(OFS_MODE, 32'h0000_0000);
    rd(8'h3C, 32'h0000_0000);
    v = $urandom;
    wr(OFS_MODE, {16'h0000, v[15:0]});
    rd(OFS_MODE, {16'h0000, v[15:0]});
    // Every direction code against every source, on both channels.
    for (int c = 0; c < 2; c++) for (int d = 0; d < 4; d++) for (int s = 0; s < 3; s++) begin
      setup(c == 1 ? 16'(d << 8) : 16'(d), 3'h7);
      pulse(2'(s), 9'd4, 8);
      cmp_val(32'(c == 1 ? cnt2 - b2 : cnt1 - b1),
              32'(d != 0 && s == (d == 3 ? 2 : (d == 1 ? c : 1 - c))));
    end
    setup(16'h0003, 3'h1);
    pulse(2'h2, 9'd4, 8);
    cmp_val(32'(cnt1 - b1), 32'h0);
    for (int p = 0; p < 4; p++) begin
      setup(16'(p << 2) | 16'h0001, 3'h1);
      repeat (8) pulse(2'h0, 9'd3, 4);
      cmp_val(32'(cnt1 - b1), 32'(8 >> p));
    end
    setup(16'h0009, 3'h1);
    repeat (3) pulse(2'h0, 9'd3, 4);
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0001);
    pulse(2'h0, 9'd3, 4);
    cmp_val(32'(cnt1 - b1), 32'h0);
    repeat (3) pulse(2'h0, 9'd3, 4);
    cmp_val(32'(cnt1 - b1), 32'h1);
    setup(16'h1500, 3'h2);
    pulse(2'h1, 9'd1, 8);
    repeat (4) pulse(2'h1, 9'd6, 6);
    cmp_val(32'(cnt2 - b2), 32'h2);
    for (int f = 0; f < 16; f++) begin
      setup(16'(f << 4) | 16'h0001, 3'h1);
      pulse(2'h0, 9'd1, 300);
      cmp_val(32'(cnt1 - b1), 32'(f == 0));
      pulse(2'h0, 9'd300, 300);
      cmp_val(32'(cnt1 - b1), 32'(f == 0) + 32'h1);
    end
    setup(16'h0060, 3'h0);
    wr(OFS_CMP, 32'h0000_8000);
    repeat (40) @(posedge sys_clk_i);
    wr(OFS_MODE, 32'h0000_0070);
    repeat (40) @(posedge sys_clk_i);
    wr(OFS_MODE, 32'h0000_0068);
    wr(OFS_CMP, {16'h0000, v[31:16]});
    rd(OFS_CMP, 32'h0000_8000);
    @(posedge sys_clk_i);
    overflow_i <= 1'b1;
    @(posedge sys_clk_i);
    overflow_i <= 1'b0;
    rd(OFS_CMP, {16'h0000, v[31:16]});
    wr(OFS_MODE, 32'h0000_0060);
    wr(OFS_CMP, 32'h0000_1234);
    rd(OFS_CMP, 32'h0000_1234);
    wr(OFS_CMP, 32'h0000_0000);
    for (int m = 0; m < 2; m++) begin
      wr(OFS_MODE, m == 0 ? 32'h0000_0064 : 32'h0000_0074);
      @(posedge sys_clk_i);
      trigger_event_i <= 1'b1;
      @(posedge sys_clk_i);
      trigger_event_i <= 1'b0;
      #1 cmp_val({31'h0, raw}, 32'(m == 0));
    end
    repeat (4) @(posedge sys_clk_i);
    complete_run();
  end
endmodule
